// ---- hdl/aqmc_pkg.sv ----
// Constants, field layout and types shared by the queue-1 mode control block.
package aqmc_pkg;

   // Register indices on the plain register port.
   localparam logic [1:0] AQMC_IDX_CLK_CONFIG = 2'h0;
   localparam logic [1:0] AQMC_IDX_Q1_MODE    = 2'h1;
   localparam logic [1:0] AQMC_IDX_STATUS     = 2'h2;

   localparam int AQMC_DATA_W     = 16;
   localparam int AQMC_ADDR_W     = 2;

   // Field positions.
   localparam int AQMC_CIE_BIT    = 15;
   localparam int AQMC_PIE_BIT    = 14;
   localparam int AQMC_SSE_BIT    = 13;
   localparam int AQMC_MODE_LSB   = 8;
   localparam int AQMC_MODE_W     = 5;
   localparam int AQMC_TRG_BIT    = 12;
   localparam int AQMC_PRESCALE_W = 7;
   localparam int AQMC_CONT_BIT   = 4;

   // Status register bit positions.
   localparam int AQMC_STAT_BUSY  = 0;
   localparam int AQMC_STAT_PAUSE = 1;
   localparam int AQMC_STAT_SSE   = 2;

   // Operating mode codes.
   localparam logic [4:0] AQMC_MODE_DISABLED    = 5'h00;
   localparam logic [4:0] AQMC_MODE_SW_SINGLE   = 5'h01;
   localparam logic [4:0] AQMC_MODE_RISE_SINGLE = 5'h02;
   localparam logic [4:0] AQMC_MODE_FALL_SINGLE = 5'h03;
   localparam logic [4:0] AQMC_MODE_GATE_SINGLE = 5'h0f;
   localparam logic [4:0] AQMC_MODE_RESERVED    = 5'h10;
   localparam logic [4:0] AQMC_MODE_SW_CONT     = 5'h11;
   localparam logic [4:0] AQMC_MODE_RISE_CONT   = 5'h12;
   localparam logic [4:0] AQMC_MODE_FALL_CONT   = 5'h13;
   localparam logic [4:0] AQMC_MODE_GATE_CONT   = 5'h1f;

   // Timer modes use low mode nibble 4..14; exponent is nibble plus 3.
   localparam logic [3:0] AQMC_TMR_FIRST   = 4'h4;
   localparam logic [3:0] AQMC_TMR_LAST    = 4'he;
   localparam logic [4:0] AQMC_TMR_EXP_OFS = 5'h03;
   localparam int         AQMC_TMR_W       = 17;

   // Prescale: zero acts as one; divisor is twice (code plus one).
   localparam logic [6:0] AQMC_PRESCALE_MIN = 7'h01;
   localparam int         AQMC_DIV_W        = 9;

   localparam logic [15:0] AQMC_CLK_CONFIG_RST = 16'h0000;

   typedef struct packed {
      logic       cie;
      logic       pie;
      logic       sse;
      logic [4:0] mode;
   } aqmc_q1ctl_s;

   localparam aqmc_q1ctl_s AQMC_Q1CTL_RST = '{1'b0, 1'b0, 1'b0, 5'h00};

   typedef struct packed {
      logic [AQMC_ADDR_W-1:0] addr;
      logic [AQMC_DATA_W-1:0] wdata;
      logic                   wr;
      logic                   rd;
   } aqmc_bus_req_s;

   typedef enum logic [1:0] {
      AQMC_IDLE  = 2'b00,
      AQMC_RUN   = 2'b01,
      AQMC_PAUSE = 2'b10
   } aqmc_state_e;

endpackage

// ---- hdl/aqmc_q1_mode_ctrl.sv ----
// Queue-1 mode control: register, prescaler, trigger routing and scan starts.
//
// Functional notes
// - Conversion clock is system clock divided by twice (prescale plus one); zero acts as one.
// - Stop mode returns the queue-1 mode register to its reset state.
// - Completion enable set requests an interrupt when the last command word finishes.
// - Pause enable set requests an interrupt when queue 1 enters pause.
// - Single-scan enable is writable but reads as zero in the mode register outside test mode; status bit 2 always shows it.
// - Hardware clears the single-scan enable once its single scan completes.
// - Single-scan modes start on a trigger only while single-scan enable is set.
// - One write may set single-scan enable and select a single-scan mode together.
// - Mode field is bits 12 to 8; code zero keeps queue 1 disabled.
// - Mode 00001 runs one software-triggered scan, started by setting single-scan enable.
// - Modes 00010 and 00011 start single scans on rising or falling trigger edges.
// - Modes 00100 to 01110 start single scans after a 2^7..2^17 conversion-clock interval.
// - Mode 01111 runs one externally gated scan, started once single-scan enable is set and the external gate is open.
// - Mode 10001 scans continuously, restarting when each pass ends.
// - Modes 10010 and 10011 start continuous passes on rising or falling edges.
// - Modes 10100 to 11110 retrigger passes from a 2^7..2^17 periodic timer.
// - Mode 11111 scans continuously while the external gate allows conversions.
// - Trigger-assignment bit swaps which external trigger input feeds each queue.
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none

module aqmc_q1_mode_ctrl
   import aqmc_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   resetn,
   input  wire logic                   stop_mode,
   input  wire logic                   test_mode,
   input  wire logic [AQMC_ADDR_W-1:0] reg_addr,
   input  wire logic [AQMC_DATA_W-1:0] reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [AQMC_DATA_W-1:0] reg_rdata,
   input  wire logic [1:0]             external_trigger_input,
   input  wire logic                   q1_last_done,
   input  wire logic                   q1_pause_done,
   output logic                        conversion_clock_en,
   output logic                        q1_start,
   output logic                        q1_busy,
   output logic                        q1_gate_open,
   output logic                        q1_completion_irq,
   output logic                        q1_pause_irq,
   output logic                        q2_trigger
);

   // Timer exponent for a timer mode: low nibble plus offset.
   function automatic logic [4:0] tmr_exp(input logic [4:0] mode);
      tmr_exp = {1'b0, mode[3:0]} + AQMC_TMR_EXP_OFS;
   endfunction

   function automatic logic is_timer_mode(input logic [4:0] mode);
      is_timer_mode = (mode[3:0] >= AQMC_TMR_FIRST) &&
                      (mode[3:0] <= AQMC_TMR_LAST);
   endfunction

   aqmc_bus_req_s                req;
   aqmc_q1ctl_s                  q1ctl_r;
   aqmc_q1ctl_s                  q1ctl_nxt;
   aqmc_state_e                  state_r;
   aqmc_state_e                  state_nxt;
   logic [AQMC_DATA_W-1:0]       clk_config_r;
   logic [AQMC_DATA_W-1:0]       rdata_r;
   logic [AQMC_DATA_W-1:0]       rdata_nxt;
   logic [AQMC_DIV_W-1:0]        div_cnt_r;
   logic [AQMC_TMR_W-1:0]        tmr_cnt_r;
   logic [1:0]                   trig_d_r;
   logic                         q1_trig_prev_r;
   logic                         conversion_clock_en_r;
   logic                         start_r;
   logic                         gate_r;
   logic                         cmp_irq_r;
   logic                         pse_irq_r;
   logic                         q2_trig_r;

   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   // ---------------- Register decode ----------------
   wire wr_cfg  = req.wr && (req.addr == AQMC_IDX_CLK_CONFIG) && !stop_mode;
   wire wr_q1   = req.wr && (req.addr == AQMC_IDX_Q1_MODE) && !stop_mode;
   wire rd_cfg  = req.rd && (req.addr == AQMC_IDX_CLK_CONFIG);
   wire rd_q1   = req.rd && (req.addr == AQMC_IDX_Q1_MODE);
   wire rd_stat = req.rd && (req.addr == AQMC_IDX_STATUS);

   wire [6:0] prescale_raw = clk_config_r[AQMC_PRESCALE_W-1:0];
   wire       trg_swap     = clk_config_r[AQMC_TRG_BIT];
   wire [4:0] mode         = q1ctl_r.mode;

   // ---------------- Prescaler ----------------
   wire [6:0] prescale_eff = (prescale_raw == 7'h00) ?
                             AQMC_PRESCALE_MIN : prescale_raw;
   // Divisor is 2*(code+1); terminal count is divisor minus one.
   wire [AQMC_DIV_W-1:0] div_last =
      {1'b0, prescale_eff, 1'b0} + 9'h001;
   wire div_wrap = (div_cnt_r >= div_last);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div_cnt_r <= '0;
         conversion_clock_en_r <= 1'b0;
      end else begin
         div_cnt_r <= div_wrap ? '0 : div_cnt_r + 9'h001;
         conversion_clock_en_r <= div_wrap;
      end
   end

   // ---------------- Trigger routing ----------------
   wire q1_trig_lvl = trg_swap ? trig_d_r[1] : trig_d_r[0];
   wire q2_trig_lvl = trg_swap ? trig_d_r[0] : trig_d_r[1];
   wire trig_rise   = q1_trig_lvl && !q1_trig_prev_r;
   wire trig_fall   = !q1_trig_lvl && q1_trig_prev_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         trig_d_r       <= 2'h0;
         q1_trig_prev_r <= 1'b0;
         q2_trig_r      <= 1'b0;
      end else begin
         trig_d_r       <= external_trigger_input;
         q1_trig_prev_r <= q1_trig_lvl;
         q2_trig_r      <= q2_trig_lvl;
      end
   end

   // ---------------- Mode decode ----------------
   wire mode_cont   = mode[AQMC_CONT_BIT];
   wire mode_off    = (mode == AQMC_MODE_DISABLED) ||
                      (mode == AQMC_MODE_RESERVED);
   wire mode_sw     = (mode == AQMC_MODE_SW_SINGLE) ||
                      (mode == AQMC_MODE_SW_CONT);
   wire mode_rise   = (mode == AQMC_MODE_RISE_SINGLE) ||
                      (mode == AQMC_MODE_RISE_CONT);
   wire mode_fall   = (mode == AQMC_MODE_FALL_SINGLE) ||
                      (mode == AQMC_MODE_FALL_CONT);
   wire mode_gate   = (mode == AQMC_MODE_GATE_SINGLE) ||
                      (mode == AQMC_MODE_GATE_CONT);
   wire mode_timer  = is_timer_mode(mode);
   wire scan_armed  = mode_cont || q1ctl_r.sse;

   // ---------------- Interval / periodic timer ----------------
   // The timer only runs while a pass could start, so an interval always
   // counts from the end of the previous pass or from arming.
   wire [4:0] exp_now = tmr_exp(mode);
   wire [AQMC_TMR_W-1:0] tmr_last =
      AQMC_TMR_W'((18'h00001 << exp_now) - 18'h00001);
   wire tmr_run    = mode_timer && scan_armed && (state_r == AQMC_IDLE);
   wire tmr_expire = tmr_run && conversion_clock_en_r && (tmr_cnt_r == tmr_last);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tmr_cnt_r <= '0;
      end else if (!tmr_run || tmr_expire || wr_q1 || stop_mode) begin
         tmr_cnt_r <= '0;
      end else if (conversion_clock_en_r) begin
         tmr_cnt_r <= tmr_cnt_r + 17'h00001;
      end
   end

   // ---------------- Trigger event per mode ----------------
   wire trig_evt =
      (mode_sw    && 1'b1)        |
      (mode_rise  && trig_rise)   |
      (mode_fall  && trig_fall)   |
      (mode_timer && tmr_expire)  |
      (mode_gate  && q1_trig_lvl);
   wire accept = trig_evt && scan_armed && !mode_off;

   wire single_done = (state_r == AQMC_RUN) && q1_last_done && !mode_cont;

   // ---------------- Scan sequencer ----------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         AQMC_IDLE: begin
            if (accept) begin
               state_nxt = AQMC_RUN;
            end
         end
         AQMC_RUN: begin
            if (q1_last_done) begin
               state_nxt = AQMC_IDLE;
            end else if (q1_pause_done) begin
               state_nxt = AQMC_PAUSE;
            end
         end
         AQMC_PAUSE: begin
            // A paused queue resumes on its next trigger event; a timer mode stays paused, as its timer runs only in idle.
            if (accept) begin
               state_nxt = AQMC_RUN;
            end
         end
         default: begin
            state_nxt = AQMC_IDLE;
         end
      endcase
      if (mode_off || stop_mode) begin
         state_nxt = AQMC_IDLE;
      end
   end

   // ---------------- Queue-1 mode register ----------------
   always_comb begin
      q1ctl_nxt = q1ctl_r;
      if (single_done) begin
         q1ctl_nxt.sse = 1'b0;
      end
      if (wr_q1) begin
         // A write lands after the hardware clear, so a fresh set wins.
         q1ctl_nxt.cie  = req.wdata[AQMC_CIE_BIT];
         q1ctl_nxt.pie  = req.wdata[AQMC_PIE_BIT];
         q1ctl_nxt.sse  = req.wdata[AQMC_SSE_BIT];
         q1ctl_nxt.mode =
            req.wdata[AQMC_MODE_LSB +: AQMC_MODE_W];
      end
      if (stop_mode) begin
         q1ctl_nxt = AQMC_Q1CTL_RST;
      end
   end

   // ---------------- Read mux ----------------
   wire [AQMC_DATA_W-1:0] q1_view =
      {q1ctl_r.cie, q1ctl_r.pie, q1ctl_r.sse && test_mode,
       q1ctl_r.mode, 8'h00};
   wire [AQMC_DATA_W-1:0] cfg_view =
      {clk_config_r[15:7], prescale_eff};
   wire [AQMC_DATA_W-1:0] stat_view =
      {13'h0000, q1ctl_r.sse, (state_r == AQMC_PAUSE),
       (state_r != AQMC_IDLE)};

   always_comb begin
      rdata_nxt = '0;
      if (rd_cfg) begin
         rdata_nxt = cfg_view;
      end else if (rd_q1) begin
         rdata_nxt = q1_view;
      end else if (rd_stat) begin
         rdata_nxt = stat_view;
      end
   end

   // Only the trigger-assignment bit and prescale field hold state.
   wire [AQMC_DATA_W-1:0] cfg_mask = 16'h107f;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         clk_config_r <= AQMC_CLK_CONFIG_RST;
         q1ctl_r      <= AQMC_Q1CTL_RST;
         state_r      <= AQMC_IDLE;
         rdata_r      <= '0;
      end else begin
         if (wr_cfg) begin
            clk_config_r <= req.wdata & cfg_mask;
         end
         q1ctl_r <= q1ctl_nxt;
         state_r <= state_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ---------------- Registered outputs ----------------
   wire start_pulse = accept && (state_r != AQMC_RUN) && !stop_mode;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         start_r   <= 1'b0;
         gate_r    <= 1'b0;
         cmp_irq_r <= 1'b0;
         pse_irq_r <= 1'b0;
      end else begin
         start_r   <= start_pulse;
         gate_r    <= mode_gate && scan_armed && q1_trig_lvl;
         cmp_irq_r <= q1ctl_r.cie && q1_last_done &&
                      (state_r == AQMC_RUN);
         pse_irq_r <= q1ctl_r.pie && q1_pause_done &&
                      (state_r == AQMC_RUN);
      end
   end

   assign reg_rdata           = rdata_r;
   assign conversion_clock_en = conversion_clock_en_r;
   assign q1_start            = start_r;
   assign q1_busy             = (state_r != AQMC_IDLE);
   assign q1_gate_open        = gate_r;
   assign q1_completion_irq   = cmp_irq_r;
   assign q1_pause_irq        = pse_irq_r;
   assign q2_trigger          = q2_trig_r;

endmodule // aqmc_q1_mode_ctrl

`default_nettype wire

// ---- tb/aqmc_q1_mode_ctrl_assertions.sv ----
// Checker for the queue-1 mode control block, bound to its ports.
`timescale 1ns/100ps
`default_nettype none
module aqmc_q1_chk
   import aqmc_pkg::*;
(
   input wire logic                   clk,
   input wire logic                   resetn,
   input wire logic                   stop_mode,
   input wire logic                   test_mode,
   input wire logic [AQMC_ADDR_W-1:0] reg_addr,
   input wire logic [AQMC_DATA_W-1:0] reg_wdata,
   input wire logic                   reg_wr,
   input wire logic                   reg_rd,
   input wire logic [AQMC_DATA_W-1:0] reg_rdata,
   input wire logic                   q1_last_done,
   input wire logic                   q1_pause_done,
   input wire logic                   conversion_clock_en,
   input wire logic                   q1_start,
   input wire logic                   q1_busy,
   input wire logic                   q1_completion_irq,
   input wire logic                   q1_pause_irq
);
   logic       cie_r, pie_r, ok_r;
   logic [4:0] mode_r;
   logic [6:0] pre_r;
   logic [8:0] gap_r;
   wire        wr_ok  = reg_wr && !stop_mode;
   wire        wr_ctl = wr_ok && reg_addr == AQMC_IDX_Q1_MODE;
   wire        wr_cfg = wr_ok && reg_addr == AQMC_IDX_CLK_CONFIG;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // A spacing is judged only once a full period ran on a settled divisor.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         {cie_r, pie_r, mode_r, ok_r, gap_r} <= '0;
         pre_r <= AQMC_PRESCALE_MIN;
      end else begin
         gap_r <= conversion_clock_en ? 9'h000 : gap_r + 9'h001;
         ok_r  <= (wr_cfg || stop_mode) ? 1'b0 : (conversion_clock_en | ok_r);
         if (stop_mode)
            {cie_r, pie_r, mode_r} <= '0;
         else if (wr_ctl)
            {cie_r, pie_r, mode_r} <= {reg_wdata[15:14], reg_wdata[12:8]};
         if (wr_cfg)
            pre_r <= (reg_wdata[6:0] == 7'h00) ? AQMC_PRESCALE_MIN
                                               : reg_wdata[6:0];
      end
   end
   property p_div; conversion_clock_en && ok_r |-> gap_r == {1'b0, pre_r, 1'b1};
   endproperty
   a_div: assert property (p_div) else $error("clock enable spacing");
   property p_hide; reg_rd && reg_addr == AQMC_IDX_Q1_MODE && !test_mode
      |=> !reg_rdata[AQMC_SSE_BIT]; endproperty
   a_hide: assert property (p_hide) else $error("scan enable visible");
   property p_resv; reg_rd && reg_addr == AQMC_IDX_Q1_MODE
      |=> reg_rdata[7:0] == 8'h00; endproperty
   a_resv: assert property (p_resv) else $error("low byte not zero");
   property p_stop; stop_mode |=> !q1_busy; endproperty
   a_stop: assert property (p_stop) else $error("busy in stop");
   property p_cie; q1_busy && q1_last_done |=> q1_completion_irq == $past(cie_r);
   endproperty
   a_cie: assert property (p_cie) else $error("completion request");
   property p_cie_src; $rose(q1_completion_irq) |-> $past(q1_last_done);
   endproperty
   a_cie_src: assert property (p_cie_src) else $error("stray request");
   property p_pie; q1_busy && q1_pause_done |=> q1_pause_irq == $past(pie_r);
   endproperty
   a_pie: assert property (p_pie) else $error("pause request");
   property p_done; q1_busy && q1_last_done |=> !q1_busy; endproperty
   a_done: assert property (p_done) else $error("scan did not end");
   property p_off; $past(mode_r) == AQMC_MODE_DISABLED |-> !q1_start;
   endproperty
   a_off: assert property (p_off) else $error("start while disabled");
endmodule // aqmc_q1_chk
bind aqmc_q1_mode_ctrl aqmc_q1_chk u_aqmc_q1_chk (.*);
`default_nettype wire

// ---- tb/aqmc_conv_model.sv ----
// Converter stand-in: answers each queue-1 start with done pulses.
`timescale 1ns/100ps
`default_nettype none
module aqmc_conv_model #(
   parameter int DLY = 6
) (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic q1_start,
   input  wire logic q1_busy,
   input  wire logic pause_req,
   output logic      q1_last_done,
   output logic      q1_pause_done
);
   logic [7:0] cnt_r;
   logic       paused_r;
   wire        fire = q1_busy && cnt_r == 8'h01;
   // One pause per pass, so a held request cannot loop forever.
   wire        hold = fire && pause_req && !paused_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         {cnt_r, paused_r, q1_last_done, q1_pause_done} <= '0;
      end else begin
         cnt_r <= q1_start ? 8'(DLY)
                  : ((q1_busy && cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00);
         q1_pause_done <= hold;
         q1_last_done  <= fire && !hold;
         if (fire)
            paused_r <= hold;
      end
   end
endmodule // aqmc_conv_model
`default_nettype wire

// ---- tb/aqmc_q1_mode_ctrl_bench.sv ----
// Self-checking bench for the queue-1 mode control block.
`timescale 1ns/100ps
`default_nettype none
module aqmc_q1_mode_ctrl_bench
   import aqmc_pkg::*;
   ;
   logic                   clk, resetn, stop_mode, test_mode, reg_wr, reg_rd;
   logic [AQMC_ADDR_W-1:0] reg_addr;
   logic [AQMC_DATA_W-1:0] reg_wdata, reg_rdata;
   logic [1:0]             trigger_assignment;
   logic                   ldone, pdone, cken, start, busy, gate, cirq;
   logic                   pirq, q2t, pause_req, sel, f;
   int                     n_fail, checks_done, n_start, n_cirq, n_pirq;
   int                     n0, c0, k;
   logic [6:0]             pcode[5] = '{7'h00, 7'h01, 7'h02, 7'h60, 7'h7f};
   int                     pdiv[5]  = '{4, 4, 6, 194, 256};
   logic [15:0]            ectl[6]  = '{16'h0200, 16'h2200, 16'h2300,
                                        16'h1200, 16'h1300, 16'h2000};
   int                     ecnt[6]  = '{0, 1, 1, 1, 1, 0};
   logic [15:0]            tm[2]    = '{16'h2400, 16'h1400};
   aqmc_q1_mode_ctrl u_aqmc_q1_mode_ctrl (
      .clk(clk), .resetn(resetn), .stop_mode(stop_mode),
      .test_mode(test_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .external_trigger_input(trigger_assignment), .q1_last_done(ldone),
      .q1_pause_done(pdone), .conversion_clock_en(cken), .q1_start(start),
      .q1_busy(busy), .q1_gate_open(gate), .q1_completion_irq(cirq),
      .q1_pause_irq(pirq), .q2_trigger(q2t));
   aqmc_conv_model u_aqmc_conv_model (
      .clk(clk), .resetn(resetn), .q1_start(start), .q1_busy(busy),
      .pause_req(pause_req), .q1_last_done(ldone), .q1_pause_done(pdone));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      n_start += (start === 1'b1);
      n_cirq  += (cirq === 1'b1);
      n_pirq  += (pirq === 1'b1);
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [15:0] exp);
      @(posedge clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
   endtask
   task automatic finish_test();
      $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #1_000_000;
      n_fail++;
      finish_test();
   end
   initial begin
      {stop_mode, test_mode, reg_wr, reg_rd, pause_req, resetn} = '0;
      {reg_addr, reg_wdata, trigger_assignment} = '0;
      {n_fail, checks_done, n_start, n_cirq, n_pirq} = '0;
      cyc(6);
      resetn <= 1'b1;
      rd(AQMC_IDX_Q1_MODE, 16'h0000);
      rd(AQMC_IDX_CLK_CONFIG, 16'h0001);
      rd(2'h3, 16'h0000);
      foreach (pcode[i]) begin
         wr(AQMC_IDX_CLK_CONFIG, {9'h000, pcode[i]});
         rd(AQMC_IDX_CLK_CONFIG, {9'h000, (pcode[i] == 7'h00) ? 7'h01 : pcode[i]});
         repeat (2) @(posedge clk iff cken === 1'b1);
         k = 0;
         do begin @(posedge clk); k++; end while (cken !== 1'b1);
         check(16'(k), 16'(pdiv[i]));
      end
      n0 = n_start;
      c0 = n_cirq;
      wr(AQMC_IDX_Q1_MODE, 16'ha100);
      rd(AQMC_IDX_Q1_MODE, 16'h8100);
      cyc(30);
      check(16'(n_start - n0), 16'h0001);
      check(16'(n_cirq - c0), 16'h0001);
      rd(AQMC_IDX_STATUS, 16'h0000);
      test_mode <= 1'b1;
      wr(AQMC_IDX_Q1_MODE, 16'h2200);
      rd(AQMC_IDX_Q1_MODE, 16'h2200);
      test_mode <= 1'b0;
      foreach (ectl[i]) begin
         sel = 1'(i % 2);
         f = ectl[i][8];
         wr(AQMC_IDX_Q1_MODE, 16'h0000);
         wr(AQMC_IDX_CLK_CONFIG, {3'h0, sel, 12'h001});
         trigger_assignment <= {sel & ~f, ~sel & ~f};
         cyc(4);
         check({15'h0, q2t}, 16'h0000);
         wr(AQMC_IDX_Q1_MODE, ectl[i]);
         cyc(4);
         n0 = n_start;
         trigger_assignment <= {sel & f, ~sel & f};
         cyc(30);
         check({15'h0, q2t}, 16'h0000);
         check(16'(n_start - n0), 16'h0000);
         trigger_assignment <= {sel & ~f, ~sel & ~f};
         cyc(30);
         check(16'(n_start - n0), 16'(ecnt[i]));
      end
      wr(AQMC_IDX_CLK_CONFIG, 16'h0001);
      trigger_assignment <= 2'b00;
      pause_req <= 1'b1;
      {n0, c0} = {n_pirq, n_cirq};
      wr(AQMC_IDX_Q1_MODE, 16'h6100);
      cyc(40);
      check(16'(n_pirq - n0), 16'h0001);
      check(16'(n_cirq - c0), 16'h0000);
      pause_req <= 1'b0;
      n0 = n_start;
      wr(AQMC_IDX_Q1_MODE, 16'h1100);
      cyc(40);
      check({15'h0, (n_start - n0) > 2}, 16'h0001);
      stop_mode <= 1'b1;
      wr(AQMC_IDX_Q1_MODE, 16'h2100);
      stop_mode <= 1'b0;
      rd(AQMC_IDX_Q1_MODE, 16'h0000);
      rd(AQMC_IDX_STATUS, 16'h0000);
      foreach (tm[i]) begin
         wr(AQMC_IDX_Q1_MODE, tm[i]);
         k = 0;
         do begin @(posedge clk); k++; end while (start !== 1'b1 && k < 700);
         check({15'h0, k > 505 && k < 525}, 16'h0001);
         wr(AQMC_IDX_Q1_MODE, 16'h0000);
      end
      n0 = n_start;
      wr(AQMC_IDX_Q1_MODE, 16'h1f00);
      trigger_assignment <= 2'b01;
      cyc(40);
      check({14'h0, gate, (n_start - n0) > 1}, 16'h0003);
      trigger_assignment <= 2'b00;
      cyc(30);
      check({15'h0, gate}, 16'h0000);
      wr(AQMC_IDX_Q1_MODE, 16'h2f00);
      n0 = n_start;
      trigger_assignment <= 2'b01;
      cyc(30);
      check(16'(n_start - n0), 16'h0001);
      finish_test();
   end
endmodule // aqmc_q1_mode_ctrl_bench
`default_nettype wire
